// ---- dbsc_pkg.sv ----
// package for the per-bank command legality tracker
package dbsc_pkg;
    localparam int BANKS = 4;
    localparam int BA_W = 2;
    localparam int CNT_W = 8;
    // timing figures in ps and the cycle counts derived at 4 ns per clock
    localparam int CLK_PERIOD_PS = 4000;
    localparam int PRECHARGE_PERIOD_PS = 15000;
    localparam int ACTIVATE_TO_ACCESS_DELAY_PS = 15000;
    localparam int WRITE_RECOVERY_TIME_PS = 15000;
    localparam int REFRESH_CYCLE_TIME_PS = 75000;
    localparam int BURST_CYCLES_I = 4;
    localparam int WRITE_TO_READ_PS = 8000;
    // least times round up
    localparam logic [CNT_W-1:0] PRECHARGE_PERIOD_CYC =
        CNT_W'((PRECHARGE_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [CNT_W-1:0] ACTIVATE_TO_ACCESS_CYC =
        CNT_W'((ACTIVATE_TO_ACCESS_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [CNT_W-1:0] WRITE_RECOVERY_CYC =
        CNT_W'((WRITE_RECOVERY_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [CNT_W-1:0] REFRESH_CYCLE_CYC =
        CNT_W'((REFRESH_CYCLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [CNT_W-1:0] WRITE_TO_READ_CYC =
        CNT_W'((WRITE_TO_READ_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [CNT_W-1:0] BURST_CYC = CNT_W'(BURST_CYCLES_I);
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

    typedef enum logic [3:0] {
        DBSC_IDLE = 4'h0,
        DBSC_ACTIVE = 4'h1,
        DBSC_RD_AP = 4'h2,
        DBSC_WR_AP = 4'h3,
        DBSC_PRECHARGING = 4'h4,
        DBSC_ROW_ACTIVATING = 4'h5,
        DBSC_WR_RECOV = 4'h6,
        DBSC_WR_RECOV_AP = 4'h7,
        DBSC_REFRESH = 4'h8
    } dbsc_state_t;

    typedef enum logic [2:0] {
        DBSC_C_NOP = 3'h0,
        DBSC_C_READ = 3'h1,
        DBSC_C_WRITE = 3'h2,
        DBSC_C_ACT = 3'h3,
        DBSC_C_PRE = 3'h4,
        DBSC_C_REF = 3'h5,
        DBSC_C_MRS = 3'h6
    } dbsc_cmd_t;

    // command pins sampled on the rising clock
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [BA_W-1:0] bank;
        logic autoprecharge_flag_line;
    } dbsc_cmd_bus_t;

    typedef struct packed {
        dbsc_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] wtr;
    } dbsc_bank_t;
endpackage

// ---- dbsc_bank_tracker.sv ----
// per-bank state tracker that flags illegal commands
`timescale 1ns/1ps
`default_nettype none

// Operation
// - In read burst with auto-precharge, deselect and nop let the burst finish and read, write, activate, refresh or mode load to that bank are illegal.
// - In write burst with auto-precharge, deselect and nop let the burst finish and every other command to that bank is illegal.
// - In either auto-precharge burst, precharge to that bank is illegal and precharge-all is always illegal.
// - A precharging bank goes idle after the precharge period, treating deselect, nop and further precharges as nop.
// - A row-activating bank goes active after the activate-to-access delay; anything but deselect or nop is illegal meanwhile.
// - After a plain write the bank recovers then goes active; a new write is accepted and a read is illegal before write-to-read time.
// - After refresh the device goes idle only after the refresh cycle time, and any non-nop command meanwhile is illegal.
// - A command illegal for one bank in a transient state may still go to other banks whose state allows it.
module dbsc_bank_tracker
    import dbsc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire dbsc_cmd_bus_t cmd_in,
    output logic illegal_cmd,
    output logic [4*BANKS-1:0] bank_state
);

    typedef struct packed {
        dbsc_bank_t [BANKS-1:0] bank;
        logic illegal;
    } dbsc_regs_t;

    dbsc_regs_t state_reg;
    dbsc_regs_t state_next;

    // strobe decode, used for the bank check and the all-bank refresh check
    function automatic dbsc_cmd_t decode(input dbsc_cmd_bus_t c);
        dbsc_cmd_t r;
        r = DBSC_C_NOP;
        if (!c.cs_n) begin
            case ({c.ras_n, c.cas_n, c.we_n})
                3'h5: r = DBSC_C_READ;
                3'h4: r = DBSC_C_WRITE;
                3'h3: r = DBSC_C_ACT;
                3'h2: r = DBSC_C_PRE;
                3'h1: r = DBSC_C_REF;
                3'h0: r = DBSC_C_MRS;
                default: r = DBSC_C_NOP;
            endcase
        end
        return r;
    endfunction

    dbsc_cmd_t cmd;
    logic pre_all;
    logic all_idle;
    logic refreshing;

    assign cmd = decode(cmd_in);
    assign pre_all = (cmd == DBSC_C_PRE) && cmd_in.autoprecharge_flag_line;

    // refresh and mode load need every bank idle
    always_comb begin
        all_idle = 1'b1;
        refreshing = 1'b0;
        for (int i = 0; i < BANKS; i++) begin
            if (state_reg.bank[i].st != DBSC_IDLE) begin
                all_idle = 1'b0;
            end
            if (state_reg.bank[i].st == DBSC_REFRESH) begin
                refreshing = 1'b1;
            end
        end
    end

    // one state step per bank; a bank only judges commands aimed at it, except the all-bank ones and any command while it refreshes
    always_comb begin
        state_next = state_reg;
        state_next.illegal = 1'b0;
        for (int i = 0; i < BANKS; i++) begin
            logic hit;
            logic bad;
            logic [CNT_W-1:0] c;
            hit = (cmd_in.bank == BA_W'(i)) || pre_all;
            bad = 1'b0;
            c = state_reg.bank[i].cnt;
            if (c != CNT_ZERO) begin
                c = c - 8'h01;
            end
            state_next.bank[i].cnt = c;
            if (state_reg.bank[i].wtr != CNT_ZERO) begin
                state_next.bank[i].wtr = state_reg.bank[i].wtr - 8'h01;
            end
            case (state_reg.bank[i].st)
                DBSC_IDLE: begin
                    if (refreshing && cmd != DBSC_C_NOP) begin
                        bad = 1'b1;
                    end else if (cmd == DBSC_C_REF) begin
                        state_next.bank[i].st = DBSC_REFRESH;
                        state_next.bank[i].cnt = REFRESH_CYCLE_CYC;
                    end else if (hit && cmd == DBSC_C_ACT) begin
                        state_next.bank[i].st = DBSC_ROW_ACTIVATING;
                        state_next.bank[i].cnt = ACTIVATE_TO_ACCESS_CYC;
                    end else if (hit && (cmd == DBSC_C_READ || cmd == DBSC_C_WRITE)) begin
                        bad = 1'b1;
                    end
                end
                DBSC_ACTIVE: begin
                    if (hit) begin
                        case (cmd)
                            DBSC_C_READ: begin
                                // the count still reads one on the edge where write-to-read is met
                                if (state_reg.bank[i].wtr > 8'h01) begin
                                    bad = 1'b1;
                                end else if (cmd_in.autoprecharge_flag_line) begin
                                    state_next.bank[i].st = DBSC_RD_AP;
                                    state_next.bank[i].cnt = BURST_CYC;
                                end
                            end
                            DBSC_C_WRITE: begin
                                state_next.bank[i].st = cmd_in.autoprecharge_flag_line ? DBSC_WR_AP : DBSC_WR_RECOV;
                                state_next.bank[i].cnt = cmd_in.autoprecharge_flag_line ? BURST_CYC : WRITE_RECOVERY_CYC;
                                state_next.bank[i].wtr = WRITE_TO_READ_CYC;
                            end
                            DBSC_C_PRE: begin
                                state_next.bank[i].st = DBSC_PRECHARGING;
                                state_next.bank[i].cnt = PRECHARGE_PERIOD_CYC;
                            end
                            DBSC_C_ACT: bad = 1'b1;
                            default: bad = 1'b0;
                        endcase
                    end
                    if (cmd == DBSC_C_REF || cmd == DBSC_C_MRS) begin
                        bad = 1'b1;
                    end
                end
                DBSC_RD_AP, DBSC_WR_AP: begin
                    // burst runs on under deselect or nop, then a read precharges and a write recovers before precharging
                    if (cmd == DBSC_C_REF || cmd == DBSC_C_MRS || pre_all) begin
                        bad = 1'b1;
                    end else if (hit && cmd != DBSC_C_NOP) begin
                        bad = 1'b1;
                    end
                    if (c == CNT_ZERO) begin
                        state_next.bank[i].st = (state_reg.bank[i].st == DBSC_WR_AP) ?
                            DBSC_WR_RECOV_AP : DBSC_PRECHARGING;
                        state_next.bank[i].cnt = (state_reg.bank[i].st == DBSC_WR_AP) ?
                            WRITE_RECOVERY_CYC : PRECHARGE_PERIOD_CYC;
                    end
                end
                DBSC_PRECHARGING: begin
                    // a repeated precharge is a nop and does not restart the period
                    if (cmd == DBSC_C_REF || cmd == DBSC_C_MRS ||
                        (hit && (cmd == DBSC_C_READ || cmd == DBSC_C_WRITE || cmd == DBSC_C_ACT))) begin
                        bad = 1'b1;
                    end
                    if (c == CNT_ZERO) begin
                        state_next.bank[i].st = DBSC_IDLE;
                    end
                end
                DBSC_ROW_ACTIVATING: begin
                    if (cmd == DBSC_C_REF || cmd == DBSC_C_MRS || (hit && cmd != DBSC_C_NOP)) begin
                        bad = 1'b1;
                    end
                    if (c == CNT_ZERO) begin
                        state_next.bank[i].st = DBSC_ACTIVE;
                    end
                end
                DBSC_WR_RECOV: begin
                    if (hit && cmd == DBSC_C_WRITE) begin
                        state_next.bank[i].st = cmd_in.autoprecharge_flag_line ? DBSC_WR_AP : DBSC_WR_RECOV;
                        state_next.bank[i].cnt = cmd_in.autoprecharge_flag_line ? BURST_CYC : WRITE_RECOVERY_CYC;
                        state_next.bank[i].wtr = WRITE_TO_READ_CYC;
                    end else if (hit && cmd == DBSC_C_READ && state_reg.bank[i].wtr <= 8'h01) begin
                        // read once write-to-read is met; without auto-precharge the recovery keeps counting
                        if (cmd_in.autoprecharge_flag_line) begin
                            state_next.bank[i].st = DBSC_RD_AP;
                            state_next.bank[i].cnt = BURST_CYC;
                        end else if (c == CNT_ZERO) begin
                            state_next.bank[i].st = DBSC_ACTIVE;
                        end
                    end else begin
                        if (cmd == DBSC_C_REF || cmd == DBSC_C_MRS || (hit && cmd != DBSC_C_NOP)) begin
                            bad = 1'b1;
                        end
                        if (c == CNT_ZERO) begin
                            state_next.bank[i].st = DBSC_ACTIVE;
                        end
                    end
                end
                DBSC_WR_RECOV_AP: begin
                    if (cmd == DBSC_C_REF || cmd == DBSC_C_MRS || (hit && cmd != DBSC_C_NOP)) begin
                        bad = 1'b1;
                    end
                    if (c == CNT_ZERO) begin
                        state_next.bank[i].st = DBSC_PRECHARGING;
                        state_next.bank[i].cnt = PRECHARGE_PERIOD_CYC;
                    end
                end
                DBSC_REFRESH: begin
                    if (cmd != DBSC_C_NOP) begin
                        bad = 1'b1;
                    end
                    if (c == CNT_ZERO) begin
                        state_next.bank[i].st = DBSC_IDLE;
                    end
                end
                default: state_next.bank[i].st = DBSC_IDLE;
            endcase
            // refresh/mode load with any bank busy is flagged by the busy bank
            if ((cmd == DBSC_C_REF || cmd == DBSC_C_MRS) && !all_idle &&
                state_reg.bank[i].st == DBSC_IDLE && !refreshing) begin
                state_next.bank[i].st = DBSC_IDLE;
                state_next.bank[i].cnt = CNT_ZERO;
            end
            if (bad) begin
                state_next.illegal = 1'b1; // illegal commands keep this bank's state, though its counters still run and other banks may take the command
                state_next.bank[i].st = state_reg.bank[i].st;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // registered outputs
    assign illegal_cmd = state_reg.illegal;
    always_comb begin
        for (int i = 0; i < BANKS; i++) begin
            bank_state[4*i +: 4] = state_reg.bank[i].st;
        end
    end

endmodule
`default_nettype wire

// ---- dbsc_sva.sv ----
// assertions on the bank tracker ports, bound into the tracker
`timescale 1ns/1ps
`default_nettype none
module dbsc_chk
    import dbsc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire dbsc_cmd_bus_t cmd_in,
    input wire logic illegal_cmd,
    input wire logic [4*BANKS-1:0] bank_state
);
    logic [3:0] cur;
    logic [3:0] b0;
    logic nop, is_act, is_rw, is_wr, is_pre;
    // addressed bank state before the edge, and the strobe decode
    assign cur = bank_state[4*cmd_in.bank +: 4];
    assign b0 = bank_state[3:0];
    // a lone low write strobe decodes as nop in the tracker as well
    assign nop = cmd_in.cs_n | (cmd_in.ras_n & cmd_in.cas_n);
    assign is_act = !cmd_in.cs_n & !cmd_in.ras_n & cmd_in.cas_n & cmd_in.we_n;
    assign is_rw = !cmd_in.cs_n & cmd_in.ras_n & !cmd_in.cas_n;
    assign is_wr = is_rw & !cmd_in.we_n;
    assign is_pre = !cmd_in.cs_n & !cmd_in.ras_n & cmd_in.cas_n & !cmd_in.we_n;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    chk_nop_never_flag: assert property (nop |=> !illegal_cmd)
        else $error("nop flagged");
    chk_rdap_flag: assert property (cur == 4'h2 && !nop |=> illegal_cmd)
        else $error("read ap burst command not flagged");
    chk_wrap_flag: assert property (cur == 4'h3 && !nop |=> illegal_cmd)
        else $error("write ap burst command not flagged");
    chk_prech_repeat: assert property (cur == 4'h4 && is_pre && !cmd_in.autoprecharge_flag_line |=> !illegal_cmd)
        else $error("repeat precharge flagged");
    chk_prech_flag: assert property (cur == 4'h4 && (is_rw || is_act) |=> illegal_cmd)
        else $error("access to precharging bank not flagged");
    chk_rowact_flag: assert property (cur == 4'h5 && !nop |=> illegal_cmd)
        else $error("command in row activation not flagged");
    chk_recov_write: assert property (cur == 4'h6 && is_wr |=> !illegal_cmd)
        else $error("write in recovery flagged");
    chk_refresh_flag: assert property (cur == 4'h8 && !nop |=> illegal_cmd)
        else $error("command in refresh not flagged");
    // a short delay count shows as a too early change; a long one only when three or more cycles late
    chk_act_delay: assert property (b0 == 4'h5 && $past(b0) != 4'h5 |-> (b0 == 4'h5) [*4] ##[1:3] b0 == 4'h1)
        else $error("activate delay wrong");
    chk_refresh_hold: assert property (bank_state == 16'h0000 && !nop && !cmd_in.ras_n && !cmd_in.cas_n
        && cmd_in.we_n |=> (bank_state == 16'h8888) [*8])
        else $error("refresh not held");
    cover property (cur == 4'h2 && !nop);
    cover property (cur == 4'h6 && is_wr);
    cover property (bank_state == 16'h8888);
endmodule

bind dbsc_bank_tracker dbsc_chk dbsc_chk_inst (.sys_clk(sys_clk), .nrst(nrst), .cmd_in(cmd_in),
    .illegal_cmd(illegal_cmd), .bank_state(bank_state));
`default_nettype wire

// ---- dbsc_ctrl_model.sv ----
// controller model that turns a command index into pin levels
`timescale 1ns/1ps
`default_nettype none
module dbsc_ctrl_model
    import dbsc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [3:0] op,
    input wire logic [BA_W-1:0] ba,
    output var dbsc_cmd_bus_t cmd_bus
);
    logic [3:0] idle_reg;
    logic [3:0] enc;
    // odd step walks all patterns, so don't-care lines never hold a stale value
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            idle_reg <= 4'h0;
        end else begin
            idle_reg <= idle_reg + 4'h5;
        end
    end
    // only what the bench asks is sent, an illegal one only on purpose
    // pins ras cas we then flag line: 1 rd,2 rd ap,3 wr,4 wr ap,5 act,6 pre,7 all,8 ref,9 mode load
    always_comb begin
        case (op)
            4'h1: enc = 4'ha;
            4'h2: enc = 4'hb;
            4'h3: enc = 4'h8;
            4'h4: enc = 4'h9;
            4'h5: enc = 4'h6;
            4'h6: enc = 4'h4;
            4'h7: enc = 4'h5;
            4'h8: enc = 4'h2;
            4'h9: enc = 4'h0;
            default: enc = {idle_reg[1] ? idle_reg[3:1] : 3'h7, idle_reg[0]};
        endcase
        cmd_bus = {1'b0, enc[3:1], ba, enc[0]};
        if (op == 4'h0) cmd_bus.cs_n = idle_reg[1]; // deselect and nop alternate every two cycles
    end
endmodule
`default_nettype wire

// ---- tb_ddr2_bank_state_command_legality.sv ----
// self-checking bench for the bank tracker
`timescale 1ns/1ps
`default_nettype none
module tb_ddr2_bank_state_command_legality
    import dbsc_pkg::*;
;
    logic sys_clk, nrst, illegal_cmd;
    logic [3:0] op;
    logic [BA_W-1:0] ba, b;
    logic [4*BANKS-1:0] bank_state;
    dbsc_cmd_bus_t cmd_in;
    int n_fail, tests_run;
    logic [1:0] e;
    logic [3:0] sts [6] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8};
    logic [3:0] setup_k [6] = '{4'h2, 4'h4, 4'h6, 4'h0, 4'h3, 4'h8};
    dbsc_ctrl_model dbsc_ctrl_model_inst (.sys_clk(sys_clk), .nrst(nrst), .op(op), .ba(ba), .cmd_bus(cmd_in));
    dbsc_bank_tracker dbsc_bank_tracker_inst (.sys_clk(sys_clk), .nrst(nrst), .cmd_in(cmd_in),
        .illegal_cmd(illegal_cmd), .bank_state(bank_state));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // 0 legal, 1 flagged; a read in recovery lands two cycles after the write, legal once write-to-read is met
    function automatic logic [1:0] exp_bad(input logic [3:0] st, input logic [3:0] k);
        if (k == 4'h0) return 2'h0;
        if (st == 4'h4) return (k == 4'h6 || k == 4'h7) ? 2'h0 : 2'h1;
        if (st == 4'h6 && k <= 4'h2) return {1'b0, WRITE_TO_READ_CYC > 8'h02};
        if (st == 4'h6) return (k == 4'h3 || k == 4'h4) ? 2'h0 : 2'h1;
        return 2'h1;
    endfunction
    task automatic chk_flag(input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD illegal_cmd expected %b seen %b", exp, got);
        end
    endtask
    task automatic chk_state(input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD bank_state expected %h seen %h", exp, got);
        end
    endtask
    // one command for one sampling edge, outputs read once that edge has landed
    task automatic issue(input logic [3:0] k, input logic [BA_W-1:0] bk);
        @(posedge sys_clk);
        op <= k;
        ba <= bk;
        @(posedge sys_clk);
        op <= 4'h0;
        #1;
    endtask
    task automatic end_sim();
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // about six times the expected run
    initial begin
        #100000;
        n_fail++;
        end_sim();
    end
    initial begin
        nrst = 1'b0;
        op = 4'h0;
        ba = 2'h0;
        n_fail = 0;
        tests_run = 0;
        b = 2'($urandom(32'h7ca6));
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        // every transient state except write recovery after auto-precharge against every command, on a random bank
        foreach (sts[i]) begin
            for (int k = 0; k < 10; k++) begin
                b = 2'($urandom);
                if (sts[i] != 4'h8) issue(4'h5, b);
                if (setup_k[i] != 4'h0) begin
                    if (sts[i] != 4'h8) repeat (8) @(posedge sys_clk);
                    issue(setup_k[i], b);
                end
                issue(4'(k), b);
                e = exp_bad(sts[i], 4'(k));
                chk_flag(e[0], illegal_cmd);
                if (e == 2'h1) chk_state({12'h000, sts[i]}, {12'h000, bank_state[4*b +: 4]});
                if (sts[i] != 4'h8) begin
                    issue(4'h5, b + 2'h1);
                    chk_flag(1'b0, illegal_cmd);
                end
                repeat (30) @(posedge sys_clk);
                issue(4'h7, b);
                repeat (25) @(posedge sys_clk);
                #1;
                chk_state(16'h0000, bank_state);
                $display("test state %0d cmd %0d done", sts[i], k);
            end
        end
        end_sim();
    end
endmodule
`default_nettype wire
